// [dls_ctrl.sv]
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// RULE1 - enter high speed via lp-11, lp-01, lp-00
// RULE2 - leave high speed by driving lp-11
// RULE3 - clock runs post interval after data tail
// RULE4 - clock runs 8 ui before data leaves lp
// RULE5 - clock lp-00 lasts 38 to 95 ns
// RULE6 - receiver ignores clock for 95-300 ns
// RULE7 - clock hs-0 tail at least 60 ns
// RULE8 - clock prepare plus zero at least 300 ns
// RULE9 - data lp-00 between 40+4ui and 85+6ui ns
// RULE10 - receiver data settle 85+6ui to 145+10ui
// RULE11 - data tail max of n*8ui, 60+n*4ui
// RULE12 - every low-power state at least 50 ns
// RULE13 - data prepare plus zero at least 145+10ui
// RULE14 - all tx and settle durations are programmable; the lp-01 and exit lp-11 states use the fixed LPX_CYC
// RULE15 - settle timers accept 40 to 2590 ns
// RULE16 - calibration clock runs 80 to 120 MHz
// RULE17 - intervals counted, minimums up, maximums down
module dls_ctrl #(
  parameter int PAY_W = 16 // payload bits per burst
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] clk_lp_o,
  output logic clk_hs_en_o,
  output logic clk_hs_o,
  output logic [1:0] dat_lp_o,
  output logic dat_hs_en_o,
  output logic dat_hs_o,
  output logic [11:0] clk_settle_o,
  output logic [11:0] hs_settle_o,
  output logic busy_o
);

  // =============================================================
  // types and state
  typedef enum logic [3:0] {
    ST_IDLE, ST_C_LP01, ST_C_PREP, ST_C_ZERO, ST_C_PRE, ST_D_LP01, ST_D_PREP,
    ST_D_ZERO, ST_D_SYNC, ST_D_PAY, ST_D_TRAIL, ST_D_EXIT, ST_C_POST,
    ST_C_TRAIL, ST_C_EXIT
  } dls_state_e;

  dls_state_e st_q; // sequencer state
  dls_state_e st_d; // next state
  logic [7:0] cnt_q; // cycles left in state
  logic [7:0] dur_d; // length of the state being entered
  logic ack_q; // bus access in its answer cycle
  logic rev_q; // reverse-direction tail
  logic [PAY_W-1:0] pay_q; // payload word
  logic [31:0] ctim_q; // clock lane timing fields
  logic [31:0] dtim_q; // data lane timing fields
  logic [PAY_W+7:0] sh_q; // outgoing bit shifter
  logic start; // accepted start request
  logic wr_ok; // write taking effect this edge
  logic [7:0] cprep, czero, ctrail, cpost, hprep, hzero, htrail, cpre;

  // =============================================================
  // helpers
  function automatic logic [7:0] mx8(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic [11:0] cl12(input logic [11:0] v);
    logic [11:0] r;
    r = v;
    if (v < 12'(dls_pkg::SET_MIN_NS)) begin
      r = 12'(dls_pkg::SET_MIN_NS);
    end else if (v > 12'(dls_pkg::SET_MAX_NS)) begin
      r = 12'(dls_pkg::SET_MAX_NS);
    end
    return r;
  endfunction

  // =============================================================
  // avalon slave, one wait state per access
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_ok = avs_write_i & ack_q;
  assign busy_o = (st_q != ST_IDLE);
  assign start = wr_ok && (avs_address_i == dls_pkg::REG_CTRL)
                 && avs_writedata_i[dls_pkg::CTRL_START_BIT] && !busy_o;

  // answer cycle toggles so back to back accesses each wait once
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end
  end

  // read data captured in the wait cycle, stands at the answer edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && !ack_q) begin
      case (avs_address_i)
        dls_pkg::REG_CTRL: avs_readdata_o <= {30'h0, rev_q, busy_o};
        dls_pkg::REG_PAYLOAD: avs_readdata_o <= 32'(pay_q);
        dls_pkg::REG_CLK_TIM: avs_readdata_o <= ctim_q;
        dls_pkg::REG_DAT_TIM: avs_readdata_o <= dtim_q;
        dls_pkg::REG_SETTLE: avs_readdata_o <= {4'h0, hs_settle_o, 4'h0, clk_settle_o};
        dls_pkg::REG_STATUS: avs_readdata_o <= {27'h0, st_q, busy_o};
        default: avs_readdata_o <= 32'h0; // unmapped reads zero
      endcase
    end
  end

  // configuration writes, timing locked while a burst runs
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rev_q <= 1'b0;
      pay_q <= '0;
      ctim_q <= dls_pkg::CLK_TIM_RST;
      dtim_q <= dls_pkg::DAT_TIM_RST;
      clk_settle_o <= dls_pkg::CSET_RST; // RULE6
      hs_settle_o <= dls_pkg::HSET_RST; // RULE10
    end else if (wr_ok && !busy_o) begin
      case (avs_address_i)
        dls_pkg::REG_CTRL: rev_q <= avs_writedata_i[dls_pkg::CTRL_REV_BIT];
        dls_pkg::REG_PAYLOAD: pay_q <= avs_writedata_i[PAY_W-1:0];
        dls_pkg::REG_CLK_TIM: ctim_q <= avs_writedata_i; // RULE14
        dls_pkg::REG_DAT_TIM: dtim_q <= avs_writedata_i; // RULE14
        dls_pkg::REG_SETTLE: begin
          // settle values held inside the device range RULE15
          clk_settle_o <= cl12(avs_writedata_i[dls_pkg::SET_CLK_LSB +: 12]);
          hs_settle_o <= cl12(avs_writedata_i[dls_pkg::SET_HS_LSB +: 12]);
        end
        default: begin
        end
      endcase
    end
  end

  // =============================================================
  // effective durations, programmed values forced into limits
  always_comb begin
    cprep = ctim_q[dls_pkg::F_PREP +: 8];
    if (cprep < 8'(dls_pkg::CPREP_MIN)) cprep = 8'(dls_pkg::CPREP_MIN); // RULE5
    if (cprep > 8'(dls_pkg::CPREP_MAX)) cprep = 8'(dls_pkg::CPREP_MAX); // RULE5
    czero = mx8(ctim_q[dls_pkg::F_ZERO +: 8], 8'(dls_pkg::CPZ_CYC) - cprep); // RULE8
    ctrail = mx8(ctim_q[dls_pkg::F_TRAIL +: 8], 8'(dls_pkg::CTRAIL_CYC)); // RULE7
    cpost = mx8(ctim_q[dls_pkg::F_LAST +: 8], 8'(dls_pkg::CPOST_CYC)); // RULE3
    hprep = dtim_q[dls_pkg::F_PREP +: 8];
    if (hprep < 8'(dls_pkg::HPREP_MIN)) hprep = 8'(dls_pkg::HPREP_MIN); // RULE9
    if (hprep > 8'(dls_pkg::HPREP_MAX)) hprep = 8'(dls_pkg::HPREP_MAX); // RULE9
    hzero = mx8(dtim_q[dls_pkg::F_ZERO +: 8], 8'(dls_pkg::HPZ_CYC) - hprep); // RULE13
    htrail = mx8(dtim_q[dls_pkg::F_TRAIL +: 8],
                 rev_q ? 8'(dls_pkg::HTR4_CYC) : 8'(dls_pkg::HTR1_CYC)); // RULE11
    cpre = mx8(dtim_q[dls_pkg::F_LAST +: 8], 8'(dls_pkg::CPRE_CYC)); // RULE4
  end

  // =============================================================
  // sequencer next state and length of the next state
  always_comb begin
    st_d = st_q;
    if (st_q == ST_IDLE) begin
      if (start) st_d = ST_C_LP01; // RULE1
    end else if (cnt_q == 8'h0) begin
      case (st_q)
        ST_C_LP01: st_d = ST_C_PREP; // RULE1
        ST_C_PREP: st_d = ST_C_ZERO;
        ST_C_ZERO: st_d = ST_C_PRE;
        ST_C_PRE: st_d = ST_D_LP01; // RULE1
        ST_D_LP01: st_d = ST_D_PREP;
        ST_D_PREP: st_d = ST_D_ZERO;
        ST_D_ZERO: st_d = ST_D_SYNC;
        ST_D_SYNC: st_d = ST_D_PAY;
        ST_D_PAY: st_d = ST_D_TRAIL;
        ST_D_TRAIL: st_d = ST_D_EXIT; // RULE2
        ST_D_EXIT: st_d = ST_C_POST;
        ST_C_POST: st_d = ST_C_TRAIL;
        ST_C_TRAIL: st_d = ST_C_EXIT; // RULE2
        default: st_d = ST_IDLE;
      endcase
    end
    case (st_d)
      ST_C_PREP: dur_d = cprep;
      ST_C_ZERO: dur_d = czero;
      ST_C_PRE: dur_d = cpre;
      ST_D_PREP: dur_d = hprep;
      ST_D_ZERO: dur_d = hzero;
      ST_D_SYNC: dur_d = 8'h08;
      ST_D_PAY: dur_d = 8'(PAY_W);
      ST_D_TRAIL: dur_d = htrail;
      ST_C_POST: dur_d = cpost - 8'(dls_pkg::LPX_CYC); // exit lp-11 counts in RULE3
      ST_C_TRAIL: dur_d = ctrail;
      default: dur_d = 8'(dls_pkg::LPX_CYC); // lp states RULE12
    endcase
  end

  // state and per-state cycle counter
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 8'h0;
    end else begin
      st_q <= st_d;
      if (st_d != st_q) begin
        cnt_q <= dur_d - 8'h1; // RULE17
      end else if (cnt_q != 8'h0) begin
        cnt_q <= cnt_q - 8'h1;
      end
    end
  end

  // =============================================================
  // clock lane pins, registered from the next state
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clk_lp_o <= dls_pkg::LP11;
      clk_hs_en_o <= 1'b0;
      clk_hs_o <= 1'b0;
    end else begin
      if (st_d == ST_C_LP01) begin
        clk_lp_o <= dls_pkg::LP01; // RULE1
      end else if (st_d inside {ST_IDLE, ST_C_EXIT}) begin
        clk_lp_o <= dls_pkg::LP11; // RULE2
      end else begin
        clk_lp_o <= dls_pkg::LP00; // RULE5
      end
      clk_hs_en_o <= !(st_d inside {ST_IDLE, ST_C_LP01, ST_C_PREP, ST_C_EXIT});
      // hs clock is the system clock divided by two RULE4
      if (st_d inside {[ST_C_PRE:ST_C_POST]}) begin
        clk_hs_o <= ~clk_hs_o;
      end else begin
        clk_hs_o <= 1'b0; // hs-0 zero and tail RULE7
      end
    end
  end

  // data lane pins and bit shifter
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dat_lp_o <= dls_pkg::LP11;
      dat_hs_en_o <= 1'b0;
      dat_hs_o <= 1'b0;
      sh_q <= '0;
    end else begin
      if (st_d == ST_D_LP01) begin
        dat_lp_o <= dls_pkg::LP01; // RULE1
      end else if (st_d inside {[ST_D_PREP:ST_D_TRAIL]}) begin
        dat_lp_o <= dls_pkg::LP00; // RULE9
      end else begin
        dat_lp_o <= dls_pkg::LP11; // RULE2
      end
      dat_hs_en_o <= (st_d inside {[ST_D_ZERO:ST_D_TRAIL]});
      if (st_d == ST_D_SYNC && st_q != ST_D_SYNC) begin
        dat_hs_o <= dls_pkg::SYNC_BYTE[0];
        sh_q <= {1'b0, pay_q, dls_pkg::SYNC_BYTE[7:1]};
      end else if (st_d inside {ST_D_SYNC, ST_D_PAY}) begin
        dat_hs_o <= sh_q[0];
        sh_q <= {1'b0, sh_q[PAY_W+7:1]};
      end else if (st_d == ST_D_TRAIL) begin
        // flipped state of the last bit, held RULE11
        if (st_q != ST_D_TRAIL) dat_hs_o <= ~dat_hs_o;
      end else begin
        dat_hs_o <= 1'b0; // hs-0 zero RULE13
      end
    end
  end

  // =============================================================
  // checks: run lengths of each lane's pin state
  logic [4:0] prv_c_q, prv_d_q;
  logic [7:0] run_c_q, run_d_q, tog_q, cz_q, dz_q;
  logic chg_c, chg_d;
  assign chg_c = {clk_lp_o, clk_hs_en_o, clk_hs_o} != prv_c_q[3:0];
  assign chg_d = {dat_lp_o, dat_hs_en_o, dat_hs_o} != prv_d_q[3:0];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prv_c_q <= 5'h1c;
      prv_d_q <= 5'h1c;
      run_c_q <= 8'h0;
      run_d_q <= 8'h0;
      tog_q <= 8'h0;
      cz_q <= 8'h0;
      dz_q <= 8'h0;
    end else begin
      prv_c_q <= {1'b1, clk_lp_o, clk_hs_en_o, clk_hs_o};
      prv_d_q <= {1'b1, dat_lp_o, dat_hs_en_o, dat_hs_o};
      run_c_q <= chg_c ? 8'h1 : ((run_c_q == 8'hff) ? run_c_q : run_c_q + 8'h1);
      run_d_q <= chg_d ? 8'h1 : ((run_d_q == 8'hff) ? run_d_q : run_d_q + 8'h1);
      tog_q <= (clk_hs_en_o && clk_hs_o != prv_c_q[0] && tog_q != 8'hff)
               ? tog_q + 8'h1 : (clk_hs_en_o && clk_hs_o != prv_c_q[0] ? tog_q : 8'h0);
      cz_q <= (clk_lp_o == dls_pkg::LP00 && !clk_hs_en_o && chg_c) ? 8'h1 : cz_q + 8'h1;
      dz_q <= (dat_lp_o == dls_pkg::LP00 && !dat_hs_en_o && chg_d) ? 8'h1 : dz_q + 8'h1;
    end
  end

  // =============================================================
  // assertions on the lane pins and settle outputs
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  clk_entry_a: assert property (chg_c && clk_lp_o == dls_pkg::LP00 && !clk_hs_en_o // RULE1
    |-> prv_c_q[3:0] == {dls_pkg::LP01, 2'b00}) else $error("clock lane skipped lp-01");
  dat_entry_a: assert property (chg_d && dat_lp_o == dls_pkg::LP01 // RULE1
    |-> prv_d_q[3:0] == {dls_pkg::LP11, 2'b00}) else $error("data lane lp-01 not from lp-11");
  hs_exit_a: assert property ($fell(dat_hs_en_o) |-> dat_lp_o == dls_pkg::LP11 ##1 // RULE2
    !dat_hs_en_o) else $error("data lane left hs without lp-11");
  post_len_a: assert property ($rose(st_q == ST_C_TRAIL) // RULE3
    |-> run_d_q >= 8'(dls_pkg::CPOST_CYC))
    else $error("clock post interval too short");
  pre_len_a: assert property (chg_d && dat_lp_o == dls_pkg::LP01 // RULE4
    |-> tog_q >= 8'(dls_pkg::CPRE_CYC)) else $error("clock pre interval too short");
  clk_prep_a: assert property (chg_c && clk_hs_en_o && !prv_c_q[1] |-> // RULE5
    run_c_q >= 8'(dls_pkg::CPREP_MIN) && run_c_q <= 8'(dls_pkg::CPREP_MAX))
    else $error("clock prepare out of window");
  clk_trail_a: assert property (chg_c && prv_c_q[1] && !clk_hs_en_o // RULE7
    |-> run_c_q >= 8'(dls_pkg::CTRAIL_CYC)) else $error("clock trail too short");
  clk_zero_a: assert property (clk_hs_o && tog_q == 8'h0 && chg_c // RULE8
    |-> cz_q >= 8'(dls_pkg::CPZ_CYC)) else $error("clock prepare plus zero too short");
  dat_prep_a: assert property (chg_d && dat_hs_en_o && !prv_d_q[1] |-> // RULE9
    run_d_q >= 8'(dls_pkg::HPREP_MIN) && run_d_q <= 8'(dls_pkg::HPREP_MAX))
    else $error("data prepare out of window");
  dat_trail_a: assert property (chg_d && prv_d_q[1] && !dat_hs_en_o |-> run_d_q >= // RULE11
    (rev_q ? 8'(dls_pkg::HTR4_CYC) : 8'(dls_pkg::HTR1_CYC))) else $error("data trail too short");
  // each lane judged on its own run, both lanes may change on one edge
  lp_len_a: assert property (chg_c && !prv_c_q[1] // RULE12
    |-> run_c_q >= 8'(dls_pkg::LPX_CYC)) else $error("clock lp state too short");
  dat_lp_len_a: assert property (chg_d && !prv_d_q[1] // RULE12
    |-> run_d_q >= 8'(dls_pkg::LPX_CYC)) else $error("data lp state too short");
  dat_zero_a: assert property ($rose(st_q == ST_D_SYNC) // RULE13
    |-> dz_q >= 8'(dls_pkg::HPZ_CYC)) else $error("data prepare plus zero too short");
  settle_rng_a: assert property (clk_settle_o >= 12'(dls_pkg::SET_MIN_NS) // RULE15
    && clk_settle_o <= 12'(dls_pkg::SET_MAX_NS) && hs_settle_o >= 12'(dls_pkg::SET_MIN_NS)
    && hs_settle_o <= 12'(dls_pkg::SET_MAX_NS)) else $error("settle value out of range");

  burst_c: cover property ($rose(busy_o) ##[1:300] $fell(busy_o));
  rev_c: cover property (rev_q && $rose(st_q == ST_D_TRAIL));
  busy_wr_c: cover property (busy_o && avs_write_i && !avs_waitrequest_o);
  // sync leader reached and settle values reprogrammed
  sync_c: cover property ($rose(st_q == ST_D_SYNC));
  settle_wr_c: cover property (wr_ok && avs_address_i == dls_pkg::REG_SETTLE && !busy_o);

endmodule

// [dls_ctrl_tb_top.sv]
`timescale 1ns/100ps
// =============================================================
// bench: avalon master, lane timing monitor, scenario tasks
module dls_ctrl_tb_top;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [2:0] adr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [1:0] clp;
  logic chen;
  logic chs;
  logic [1:0] dlp;
  logic dhen;
  logic dhs;
  logic [11:0] cset;
  logic [11:0] hset;
  logic busy;
  logic [15:0] rx_pay;
  logic rx_bad;
  logic [31:0] q;
  logic bsy_q = 1'b0;
  logic dprev;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int t_c01, t_c00, t_chs, t_ctog, t_c1, t_d01, t_d00, t_dhs, t_sy, t_tr, t_dend, t_cend, t_end;

  dls_ctrl dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .clk_lp_o(clp), .clk_hs_en_o(chen), .clk_hs_o(chs),
    .dat_lp_o(dlp), .dat_hs_en_o(dhen), .dat_hs_o(dhs), .clk_settle_o(cset),
    .hs_settle_o(hset), .busy_o(busy));
  dls_rx_model rx_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .dat_hs_en_i(dhen),
    .dat_hs_i(dhs), .clk_settle_i(cset), .hs_settle_i(hset), .pay_o(rx_pay), .bad_o(rx_bad));

  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // =============================================================
  // lane monitor: cycle of each phase change within a burst
  always @(posedge clk_i) begin
    cyc++;
    if (busy === 1'b1 && bsy_q !== 1'b1) begin
      {t_c01, t_c00, t_chs, t_ctog, t_d01, t_d00, t_dhs, t_sy} = {8{-32'sd1}};
    end
    if (busy === 1'b1) begin
      if (t_c01 < 0 && clp == dls_pkg::LP01) t_c01 = cyc;
      if (t_c00 < 0 && t_c01 >= 0 && !chen && clp == dls_pkg::LP00) t_c00 = cyc;
      if (t_chs < 0 && chen) t_chs = cyc;
      if (t_ctog < 0 && chen && chs) t_ctog = cyc;
      if (chs) t_c1 = cyc;
      if (t_d01 < 0 && dlp == dls_pkg::LP01) t_d01 = cyc;
      if (t_d00 < 0 && t_d01 >= 0 && !dhen && dlp == dls_pkg::LP00) t_d00 = cyc;
      if (t_dhs < 0 && dhen) t_dhs = cyc;
      if (t_sy < 0 && dhen && dhs) t_sy = cyc - 3;
      if (dhen && dhs !== dprev) t_tr = cyc;
      dprev = dhen ? dhs : 1'b0;
      if (dhen) t_dend = cyc + 1;
      if (chen) t_cend = cyc + 1;
    end
    if (busy !== 1'b1 && bsy_q === 1'b1) t_end = cyc;
    bsy_q <= busy;
  end

  // =============================================================
  // compare tasks and closing
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(input string nm, input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic test_done;
    $display("tests run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one avalon access: hold until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
    end while (wreq !== 1'b0);
    // answer edge: write lands and read data is taken here
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_idle;
    repeat (600) begin
      @(posedge clk_i);
      if (busy === 1'b0 && bsy_q === 1'b0) return;
    end
    chk("busy", 32'h0, 32'(busy));
  endtask

  // =============================================================
  // scenarios
  task automatic t_reset;
    chk("clk lp idle", 32'(dls_pkg::LP11), 32'(clp));
    chk("dat lp idle", 32'(dls_pkg::LP11), 32'(dlp));
    bus(1'b0, dls_pkg::REG_CLK_TIM, 32'h0);
    chk("clk_tim", 32'h37030a02, q);
    bus(1'b0, dls_pkg::REG_DAT_TIM, 32'h0);
    chk("dat_tim", 32'h08080a06, q);
    bus(1'b0, dls_pkg::REG_SETTLE, 32'h0);
    chk("settle", 32'h012c00c8, q);
    bus(1'b1, 3'h7, 32'hffffffff);
    bus(1'b0, 3'h7, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
  endtask
  task automatic t_settle;
    bus(1'b1, dls_pkg::REG_SETTLE, 32'h00000fff);
    chk("clk settle hi", 32'd2590, 32'(cset));
    chk("hs settle lo", 32'd40, 32'(hset));
    bus(1'b1, dls_pkg::REG_SETTLE, 32'h012c00c8);
    chk("clk settle", 32'd200, 32'(cset));
    chk("hs settle", 32'd300, 32'(hset));
    $display("test settle done");
  endtask
  task automatic t_burst(input logic rev, input logic [15:0] pay, input int cz, input int cp,
                         input int dp, input int ctr, input int dtr);
    bus(1'b1, dls_pkg::REG_PAYLOAD, 32'(pay));
    bus(1'b1, dls_pkg::REG_CTRL, {30'h0, rev, 1'b1});
    bus(1'b1, dls_pkg::REG_PAYLOAD, 32'h0);
    bus(1'b1, dls_pkg::REG_CTRL, 32'h1);
    wait_idle();
    chk_rng("clk lp01", t_c00 - t_c01, dls_pkg::LPX_CYC, 99);
    chk_rng("clk prep", t_chs - t_c00, cp, cp);
    chk_rng("clk prep zero", t_ctog - t_c00, dls_pkg::CPZ_CYC, 99);
    chk_rng("clk zero", t_ctog - t_chs, cz, 99);
    chk_rng("clk pre", t_d01 - t_ctog, dls_pkg::CPRE_CYC, 99);
    chk_rng("dat lp01", t_d00 - t_d01, dls_pkg::LPX_CYC, 99);
    chk_rng("dat prep", t_dhs - t_d00, dp, dp);
    chk_rng("dat prep zero", t_sy - t_d00, dls_pkg::HPZ_CYC, 99);
    chk_rng("dat trail", t_dend - t_tr, dtr, 99);
    chk_rng("clk post", t_c1 + 1 - t_dend, dls_pkg::CPOST_CYC, 999);
    chk_rng("clk trail", t_cend - t_c1 - 1, ctr, 99);
    chk_rng("clk lp11", t_end - t_cend, dls_pkg::LPX_CYC, 99);
    chk("payload", 32'(pay), 32'(rx_pay));
    chk("settle ok", 32'h0, 32'(rx_bad));
    chk("dat lp end", 32'(dls_pkg::LP11), 32'(dlp));
    bus(1'b0, dls_pkg::REG_PAYLOAD, 32'h0);
    chk("busy write", 32'(pay), q);
    bus(1'b0, dls_pkg::REG_CTRL, 32'h0);
    chk("ctrl", {30'h0, rev, 1'b0}, q);
    bus(1'b0, dls_pkg::REG_STATUS, 32'h0);
    chk("status", 32'h0, q);
    $display("test burst done");
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_settle();
    t_burst(1'b0, 16'ha5c3, 10, 2, 6, 3, dls_pkg::HTR1_CYC);
    t_burst(1'b1, 16'h0001, 10, 2, 6, 3, dls_pkg::HTR4_CYC);
    bus(1'b1, dls_pkg::REG_CLK_TIM, 32'h40061401);
    bus(1'b1, dls_pkg::REG_DAT_TIM, 32'h0c0c100f);
    t_burst(1'b0, 16'h7e18, 20, 2, 9, 6, 12);
    test_done();
  end

  // watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    test_done();
  end
endmodule

// [dls_pkg.sv]
// =============================================================
// lane mode sequencer constants
package dls_pkg;

  // =============================================================
  // clock and unit interval
  localparam int CLK_NS = 25; // system clock period
  localparam int UI_NS = 25; // one high-speed bit per system clock

  // =============================================================
  // line timing, ns figures and derived cycle counts
  // minimums round up, maximums round down RULE17
  localparam int LPX_NS = 50; // shortest low-power state
  localparam int LPX_CYC = (LPX_NS + CLK_NS - 1) / CLK_NS;
  localparam int CPREP_MIN_NS = 38; // clock lane lp-00 window
  localparam int CPREP_MAX_NS = 95;
  localparam int CPREP_MIN = (CPREP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CPREP_MAX = CPREP_MAX_NS / CLK_NS;
  localparam int CPZ_NS = 300; // clock prepare plus zero
  localparam int CPZ_CYC = (CPZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CPRE_UI = 8; // clock run before data leaves lp
  localparam int CPRE_CYC = (CPRE_UI * UI_NS + CLK_NS - 1) / CLK_NS;
  localparam int CTRAIL_NS = 60; // clock hs-0 tail
  localparam int CTRAIL_CYC = (CTRAIL_NS + CLK_NS - 1) / CLK_NS;
  localparam int CPOST_NS = 60 + 52 * UI_NS; // clock run after data tail
  localparam int CPOST_CYC = (CPOST_NS + CLK_NS - 1) / CLK_NS;
  localparam int HPREP_MIN_NS = 40 + 4 * UI_NS; // data lane lp-00 window
  localparam int HPREP_MAX_NS = 85 + 6 * UI_NS;
  localparam int HPREP_MIN = (HPREP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int HPREP_MAX = HPREP_MAX_NS / CLK_NS;
  localparam int HPZ_NS = 145 + 10 * UI_NS; // data prepare plus zero
  localparam int HPZ_CYC = (HPZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int HTR1_NS = (8 * UI_NS > 60 + 4 * UI_NS) ? 8 * UI_NS : 60 + 4 * UI_NS;
  localparam int HTR4_NS = (32 * UI_NS > 60 + 16 * UI_NS) ? 32 * UI_NS : 60 + 16 * UI_NS;
  localparam int HTR1_CYC = (HTR1_NS + CLK_NS - 1) / CLK_NS; // forward tail
  localparam int HTR4_CYC = (HTR4_NS + CLK_NS - 1) / CLK_NS; // reverse tail

  // =============================================================
  // receiver settle programming, in ns
  localparam int SET_MIN_NS = 40; // programmable range of the device
  localparam int SET_MAX_NS = 2590;
  localparam int CSET_DEF_NS = 200; // inside 95 to 300 ns RULE6
  localparam int HSET_DEF_NS = 300; // inside 235 to 395 ns RULE10

  // =============================================================
  // register map, word index
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_PAYLOAD = 3'h1;
  localparam logic [2:0] REG_CLK_TIM = 3'h2;
  localparam logic [2:0] REG_DAT_TIM = 3'h3;
  localparam logic [2:0] REG_SETTLE = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;

  // =============================================================
  // field positions
  localparam int CTRL_START_BIT = 0; // write 1 starts a burst
  localparam int CTRL_REV_BIT = 1; // reverse-direction tail length
  localparam int F_PREP = 0; // prepare field of timing registers
  localparam int F_ZERO = 8;
  localparam int F_TRAIL = 16;
  localparam int F_LAST = 24; // post for clock, pre for data
  localparam int SET_CLK_LSB = 0;
  localparam int SET_HS_LSB = 16;

  // =============================================================
  // reset values
  localparam logic [31:0] CLK_TIM_RST = {8'(CPOST_CYC), 8'(CTRAIL_CYC),
                                         8'(CPZ_CYC - CPREP_MIN), 8'(CPREP_MIN)};
  localparam logic [31:0] DAT_TIM_RST = {8'(CPRE_CYC), 8'(HTR1_CYC),
                                         8'(HPZ_CYC - HPREP_MIN), 8'(HPREP_MIN)};
  localparam logic [11:0] CSET_RST = 12'(CSET_DEF_NS);
  localparam logic [11:0] HSET_RST = 12'(HSET_DEF_NS);
  localparam logic [7:0] SYNC_BYTE = 8'hb8; // leader sent lsb first

  // line state codes, bit 1 is the p wire
  localparam logic [1:0] LP11 = 2'h3;
  localparam logic [1:0] LP01 = 2'h1;
  localparam logic [1:0] LP00 = 2'h0;

endpackage

// [dls_rx_model.sv]
`timescale 1ns/100ps
// =============================================================
// receiver side of the lanes: finds the leader, takes the payload
module dls_rx_model #(
  parameter int PAY_W = 16, // payload bits per burst
  parameter int CAL_MHZ = 100 // calibration clock of the settle timers
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic dat_hs_en_i,
  input wire logic dat_hs_i,
  input wire logic [11:0] clk_settle_i,
  input wire logic [11:0] hs_settle_i,
  output logic [PAY_W-1:0] pay_o,
  output logic bad_o
);
  logic [7:0] sh_q; // last eight bits, first bit at lsb
  logic [7:0] cnt_q; // payload bits taken
  logic hunt_q; // still looking for the leader
  logic en_q; // lane hs enable one cycle ago
  // bit capture: hunt for the leader, then shift payload lsb first
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sh_q <= 8'h00;
      cnt_q <= 8'h00;
      hunt_q <= 1'b1;
      pay_o <= '0;
    end else if (!dat_hs_en_i) begin
      sh_q <= 8'h00;
      hunt_q <= 1'b1;
      cnt_q <= 8'h00;
    end else if (hunt_q) begin
      sh_q <= {dat_hs_i, sh_q[7:1]};
      if ({dat_hs_i, sh_q[7:1]} == dls_pkg::SYNC_BYTE) begin
        hunt_q <= 1'b0;
      end
    end else if (cnt_q < 8'(PAY_W)) begin
      pay_o <= {dat_hs_i, pay_o[PAY_W-1:1]};
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // settle values checked as the data lane enters high speed
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_q <= 1'b0;
      bad_o <= 1'b0;
    end else begin
      en_q <= dat_hs_en_i;
      if (dat_hs_en_i && !en_q) begin
        if (clk_settle_i < 12'h05f || clk_settle_i > 12'h12c) bad_o <= 1'b1;
        if (hs_settle_i < 12'h0eb || hs_settle_i > 12'h18b) bad_o <= 1'b1;
        if (clk_settle_i < 12'h028 || clk_settle_i > 12'ha1e) bad_o <= 1'b1;
        if (hs_settle_i < 12'h028 || hs_settle_i > 12'ha1e) bad_o <= 1'b1;
        if (CAL_MHZ < 80 || CAL_MHZ > 120) bad_o <= 1'b1;
      end
    end
  end
endmodule
